// *** src/adc_control_config.sv ***
// control logic of an 8-channel 12-bit SAR converter with register file, triggers and DMA
// assumes the analog core converts on core_clk_o after core_start_o and answers with core_done_i
// Functional notes
// R1 - eight analog channels are selectable and each conversion yields a 12-bit result.
// R2 - the code from the core is kept as straight binary, one step being full scale over 4096.
// R3 - the result lands in the high and low result registers with the channel code on top.
// R4 - single and continuous conversions start from software or from the external pin.
// R5 - in DMA mode conversions repeat and samples go to external memory with 24-bit addresses.
// R6 - after power-up the factory calibration values are loaded into offset and gain registers.
// R7 - the temperature voltage is reachable as a ninth channel through the multiplexer.
// R8 - bit 7 of control one powers the converter up when set and down when clear.
// R9 - bit 6 of control one picks the external reference when set, internal when clear.
// R10 - bits 5:4 divide the master clock by 8, 4, 16 or 32 for codes 00, 01, 10, 11.
// R11 - software keeps the converter clock at or below 4.5 MHz.
// R12 - bits 3:2 give an acquisition of 1 to 4 converter clocks, three or more advised.
// R13 - with bit 1 set a timer overflow starts a conversion when idle; one arriving while busy only sets the missed flag.
// R14 - with bit 0 set a low pulse on the external convert pin starts a conversion.
// R15 - control one resets to zero: off, internal reference, divide by 8, one clock, no triggers.
// R16 - control one is written as a whole byte and all its fields read back.
// R17 - the done flag sets at the end of a single conversion or DMA block and clears on vectoring.
`default_nettype none
module adc_control_config
  import adc_control_pkg::*;
#(
  parameter int unsigned DMA_ADDR_W = 24,
  parameter int unsigned DMA_COUNT_W = 16,
  // factory calibration defaults, values arbitrary
  parameter logic [15:0] CAL_OFFSET_FACTORY = 16'h0000,
  parameter logic [15:0] CAL_GAIN_FACTORY = 16'h8000
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_BITS-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic irq_ack_i,
  input wire logic timer_overflow_i,
  input wire logic external_convert_pin_n_i,
  output logic core_power_o,
  output logic core_reference_select_bit_o,
  output logic core_clk_o,
  output logic [CHAN_BITS-1:0] core_channel_o,
  output logic core_track_o,
  output logic core_start_o,
  input wire logic core_done_i,
  input wire logic [RES_BITS-1:0] core_code_i,
  output logic [15:0] cal_offset_o,
  output logic [15:0] cal_gain_o,
  output logic dma_valid_o,
  input wire logic dma_ready_i,
  output logic [DMA_ADDR_W-1:0] dma_addr_o,
  output logic [15:0] dma_data_o
);
  if (DMA_ADDR_W < 16 || DMA_ADDR_W > 24) $error("dma address width must be 16 to 24");
  if (DMA_COUNT_W < 1 || DMA_COUNT_W > 32) $error("dma count width must be 1 to 32");

  // bus slave: one wait cycle, then the access completes
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_en, wr_b0;
  control_one_t ctl1_q, ctl1_d;
  control_two_t ctl2_q, ctl2_d;
  result_t result_q, result_d;
  logic [IRQ_EVENTS-1:0] status_q, status_d, mask_q, mask_d, irq_set;
  logic [DMA_ADDR_W-1:0] dma_base_q, dma_base_d;
  logic [DMA_COUNT_W-1:0] dma_count_q, dma_count_d;
  logic [15:0] cal_off_q, cal_off_d, cal_gain_q, cal_gain_d;
  logic cal_pend_q;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_en = avs_write_i & ack_q;
  assign wr_b0 = wr_en & avs_byteenable_i[0];
  assign avs_readdata_o = rdata_q;

  always_comb
  begin
    ack_d = (avs_read_i | avs_write_i) & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read_i && !ack_q)
      case (avs_address_i)
        OFS_CONTROL_ONE: rdata_d = {24'h000000, ctl1_q}; // R16
        OFS_CONTROL_TWO: rdata_d = {24'h000000, status_q[IRQ_DONE], ctl2_q};
        OFS_RESULT_LOW: rdata_d = {24'h000000, result_q.code[7:0]};
        OFS_RESULT_HIGH: rdata_d = {24'h000000, result_q.channel, result_q.code[11:8]}; // R3
        OFS_IRQ_STATUS: rdata_d = {30'h0, status_q};
        OFS_IRQ_MASK: rdata_d = {30'h0, mask_q};
        OFS_DMA_BASE: rdata_d = 32'(dma_base_q);
        OFS_DMA_COUNT: rdata_d = 32'(dma_count_q);
        OFS_CAL_OFFSET: rdata_d = {16'h0000, cal_off_q};
        OFS_CAL_GAIN: rdata_d = {16'h0000, cal_gain_q};
        default: rdata_d = 32'h00000000;
      endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // converter clock divider, stopped while powered down
  logic [4:0] div_cnt_q, div_cnt_d;
  logic core_clk_q, core_clk_d, conv_tick;
  logic [4:0] div_end;

  assign div_end = div_last({ctl1_q.clock_divide_hi, ctl1_q.clock_divide_lo});
  assign conv_tick = ctl1_q.converter_power_bit && (div_cnt_q >= div_end); // R10

  always_comb
  begin
    div_cnt_d = 5'h00;
    if (ctl1_q.converter_power_bit && !conv_tick)
      div_cnt_d = div_cnt_q + 5'h01;
    core_clk_d = ctl1_q.converter_power_bit && (div_cnt_d > (div_end >> 1)); // R10
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_cnt_q <= 5'h00;
      core_clk_q <= 1'b0;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
      core_clk_q <= core_clk_d;
    end
  end

  // conversion sequencer
  conv_state_t st_q, st_d;
  logic [1:0] acq_cnt_q, acq_cnt_d;
  logic [CHAN_BITS-1:0] chan_q, chan_d;
  logic start_q, start_d, pin_prev_q, pin_fall, hw_trig, start_go;
  logic conv_end, dma_end;
  logic [DMA_ADDR_W-1:0] dma_ptr_q, dma_ptr_d;
  logic [DMA_COUNT_W-1:0] dma_left_q, dma_left_d;

  assign pin_fall = pin_prev_q & ~external_convert_pin_n_i;
  assign hw_trig = (ctl1_q.timer_trigger_enable & timer_overflow_i) // R13
                 | (ctl1_q.pin_trigger_enable & pin_fall); // R14
  assign start_go = ctl1_q.converter_power_bit
                  & (ctl2_q.single | ctl2_q.continuous | ctl2_q.dma_enable | hw_trig); // R4

  always_comb
  begin
    st_d = st_q;
    acq_cnt_d = acq_cnt_q;
    chan_d = chan_q;
    start_d = 1'b0;
    result_d = result_q;
    dma_ptr_d = dma_ptr_q;
    dma_left_d = dma_left_q;
    conv_end = 1'b0;
    dma_end = 1'b0;
    case (st_q)
      ST_IDLE:
        if (start_go)
        begin
          st_d = ST_ACQUIRE;
          acq_cnt_d = 2'h0;
          chan_d = ctl2_q.channel; // R1 R7
          if (ctl2_q.dma_enable)
          begin
            dma_ptr_d = dma_base_q;
            dma_left_d = dma_count_q;
          end
        end
      ST_ACQUIRE:
        if (conv_tick && acq_cnt_q == ctl1_q.acquisition_length) // R12
        begin
          st_d = ST_CONVERT;
          start_d = 1'b1;
        end
        else if (conv_tick)
          acq_cnt_d = acq_cnt_q + 2'h1;
      ST_CONVERT:
        if (core_done_i)
        begin
          result_d = '{channel: chan_q, code: core_code_i}; // R2 R3
          st_d = ctl2_q.dma_enable ? ST_STORE : ST_IDLE;
          conv_end = !ctl2_q.dma_enable;
        end
      ST_STORE:
        if (dma_ready_i) // R5
        begin
          dma_ptr_d = dma_ptr_q + DMA_ADDR_W'(DMA_ADDR_STEP);
          dma_left_d = dma_left_q - DMA_COUNT_W'(1);
          acq_cnt_d = 2'h0;
          dma_end = dma_left_q <= DMA_COUNT_W'(1);
          st_d = dma_end ? ST_IDLE : ST_ACQUIRE;
        end
      default: st_d = ST_IDLE;
    endcase
    // no start pulse can be pending here: conv_tick is low while powered down
    if (!ctl1_q.converter_power_bit) // R8
      st_d = ST_IDLE;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q <= ST_IDLE;
      acq_cnt_q <= 2'h0;
      chan_q <= '0;
      start_q <= 1'b0;
      pin_prev_q <= 1'b1;
      result_q <= '0;
      dma_ptr_q <= '0;
      dma_left_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      acq_cnt_q <= acq_cnt_d;
      chan_q <= chan_d;
      start_q <= start_d;
      pin_prev_q <= external_convert_pin_n_i;
      result_q <= result_d;
      dma_ptr_q <= dma_ptr_d;
      dma_left_q <= dma_left_d;
    end
  end

  // software registers, interrupts and calibration
  assign irq_set[IRQ_DONE] = conv_end | dma_end; // R17
  assign irq_set[IRQ_MISSED] = hw_trig & (st_q != ST_IDLE);

  always_comb
  begin
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    mask_d = mask_q;
    dma_base_d = dma_base_q;
    dma_count_d = dma_count_q;
    cal_off_d = cal_off_q;
    cal_gain_d = cal_gain_q;
    if (wr_b0 && avs_address_i == OFS_CONTROL_ONE)
      ctl1_d = control_one_t'(avs_writedata_i[7:0]); // R16
    if (conv_end && !ctl2_q.continuous)
      ctl2_d.single = 1'b0; // R4
    if (dma_end)
      ctl2_d.dma_enable = 1'b0; // R5
    if (wr_b0 && avs_address_i == OFS_CONTROL_TWO)
      ctl2_d = control_two_t'(avs_writedata_i[6:0]);
    if (wr_b0 && avs_address_i == OFS_IRQ_MASK)
      mask_d = avs_writedata_i[IRQ_EVENTS-1:0];
    if (wr_en && avs_address_i == OFS_DMA_BASE)
      dma_base_d = avs_writedata_i[DMA_ADDR_W-1:0];
    if (wr_en && avs_address_i == OFS_DMA_COUNT)
      dma_count_d = avs_writedata_i[DMA_COUNT_W-1:0];
    if (wr_en && avs_address_i == OFS_CAL_OFFSET)
      cal_off_d = avs_writedata_i[15:0];
    if (wr_en && avs_address_i == OFS_CAL_GAIN)
      cal_gain_d = avs_writedata_i[15:0];
    if (cal_pend_q) // R6
    begin
      cal_off_d = CAL_OFFSET_FACTORY;
      cal_gain_d = CAL_GAIN_FACTORY;
    end
  end

  // sticky flags: the set wins over a write-one clear or a vector acknowledge
  for (genvar i = 0; i < IRQ_EVENTS; i++)
  begin : g_irq
    logic clr;
    assign clr = (wr_b0 && avs_address_i == OFS_IRQ_STATUS && avs_writedata_i[i])
               || (i == IRQ_DONE && irq_ack_i); // R17
    assign status_d[i] = irq_set[i] | (status_q[i] & ~clr);
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctl1_q <= control_one_t'(CONTROL_ONE_RST); // R15
      ctl2_q <= control_two_t'(CONTROL_TWO_RST);
      status_q <= '0;
      mask_q <= '0;
      dma_base_q <= '0;
      dma_count_q <= '0;
      cal_off_q <= 16'h0000;
      cal_gain_q <= 16'h0000;
      cal_pend_q <= 1'b1;
    end
    else
    begin
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      status_q <= status_d;
      mask_q <= mask_d;
      dma_base_q <= dma_base_d;
      dma_count_q <= dma_count_d;
      cal_off_q <= cal_off_d;
      cal_gain_q <= cal_gain_d;
      cal_pend_q <= 1'b0;
    end
  end

  assign irq_o = |(status_q & mask_q);
  assign core_power_o = ctl1_q.converter_power_bit; // R8
  assign core_reference_select_bit_o = ctl1_q.reference_select_bit; // R9
  assign core_clk_o = core_clk_q;
  assign core_channel_o = chan_q;
  assign core_track_o = (st_q == ST_ACQUIRE);
  assign core_start_o = start_q;
  assign cal_offset_o = cal_off_q;
  assign cal_gain_o = cal_gain_q;
  // sample word: channel tag on top, as in the high result register
  assign dma_valid_o = (st_q == ST_STORE);
  assign dma_addr_o = dma_ptr_q;
  assign dma_data_o = result_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_reset_value: assert property (cal_pend_q |-> ctl1_q == control_one_t'(CONTROL_ONE_RST)) // R15
    else $error("control one not zero after reset");
  a_cal_factory: assert property (cal_pend_q |=> cal_offset_o == CAL_OFFSET_FACTORY
                                  && cal_gain_o == CAL_GAIN_FACTORY) // R6
    else $error("calibration not loaded at power-up");
  a_power_down_idle: assert property (!ctl1_q.converter_power_bit |=> st_q == ST_IDLE
                                      && !core_clk_o) // R8
    else $error("converter active while powered down");
  a_ref_write: assert property (wr_b0 && avs_address_i == OFS_CONTROL_ONE
                                |=> core_reference_select_bit_o == $past(avs_writedata_i[6])) // R9
    else $error("reference select does not follow write");
  a_div_wrap: assert property (conv_tick |=> div_cnt_q == 5'h00) // R10
    else $error("divider did not wrap at its last count");
  a_acq_length: assert property (st_q == ST_ACQUIRE && st_d == ST_CONVERT
                                 |-> acq_cnt_q == ctl1_q.acquisition_length) // R12
    else $error("acquisition length wrong");
  a_timer_start: assert property (st_q == ST_IDLE && ctl1_q.converter_power_bit
                                  && ctl1_q.timer_trigger_enable && timer_overflow_i
                                  |=> st_q == ST_ACQUIRE) // R13
    else $error("timer overflow did not start a conversion");
  a_pin_start: assert property (st_q == ST_IDLE && ctl1_q.converter_power_bit
                                && ctl1_q.pin_trigger_enable && $fell(external_convert_pin_n_i)
                                |=> st_q == ST_ACQUIRE) // R14
    else $error("convert pin did not start a conversion");
  a_result_tag: assert property (st_q == ST_CONVERT && core_done_i
                                 |=> result_q.channel == $past(chan_q)
                                 && result_q.code == $past(core_code_i)) // R3
    else $error("result or channel tag wrong");
  a_done_flag: assert property (conv_end |=> status_q[IRQ_DONE]) // R17
    else $error("done flag not set at conversion end");
  a_single_clear: assert property (conv_end && !ctl2_q.continuous
                                   && !(wr_b0 && avs_address_i == OFS_CONTROL_TWO)
                                   |=> !ctl2_q.single) // R4
    else $error("single bit not cleared at conversion end");
  a_dma_finish: assert property (st_q == ST_STORE && dma_ready_i && dma_left_q <= DMA_COUNT_W'(1)
                                 |=> st_q == ST_IDLE && status_q[IRQ_DONE]) // R5
    else $error("dma block did not end");
  a_bus_wait: assert property (avs_read_i && !ack_q |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not one cycle late");

  c_single_done: cover property (st_q == ST_CONVERT ##1 conv_end);
  c_dma_block: cover property (dma_end);
  c_pin_start: cover property (st_q == ST_IDLE && pin_fall && start_go ##1 st_q == ST_ACQUIRE);
  c_irq_raised: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// *** src/adc_control_pkg.sv ***
// register map, field layouts, reset values and states of the converter control block
// assumes a 32-bit Avalon-MM slave port with byte addresses and one analog core beside it
`default_nettype none
package adc_control_pkg;
  localparam int unsigned RES_BITS = 12;
  localparam int unsigned CHAN_BITS = 4;
  localparam int unsigned ADDR_BITS = 6;
  // byte offsets, one aligned word per register
  localparam logic [5:0] OFS_CONTROL_ONE = 6'h00;
  localparam logic [5:0] OFS_CONTROL_TWO = 6'h04;
  localparam logic [5:0] OFS_RESULT_LOW = 6'h08;
  localparam logic [5:0] OFS_RESULT_HIGH = 6'h0c;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h10;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h14;
  localparam logic [5:0] OFS_DMA_BASE = 6'h18;
  localparam logic [5:0] OFS_DMA_COUNT = 6'h1c;
  localparam logic [5:0] OFS_CAL_OFFSET = 6'h20;
  localparam logic [5:0] OFS_CAL_GAIN = 6'h24;
  localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
  localparam logic [6:0] CONTROL_TWO_RST = 7'h00;
  localparam logic [3:0] TEMP_CHANNEL = 4'h8;
  // interrupt status bit positions
  localparam int unsigned IRQ_EVENTS = 2;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_MISSED = 1;
  localparam logic [1:0] DMA_ADDR_STEP = 2'h2;

  typedef struct packed {
    logic converter_power_bit;
    logic reference_select_bit;
    logic clock_divide_hi;
    logic clock_divide_lo;
    logic [1:0] acquisition_length;
    logic timer_trigger_enable;
    logic pin_trigger_enable;
  } control_one_t;

  typedef struct packed {
    logic dma_enable;
    logic continuous;
    logic single;
    logic [CHAN_BITS-1:0] channel;
  } control_two_t;

  typedef struct packed {
    logic [CHAN_BITS-1:0] channel;
    logic [RES_BITS-1:0] code;
  } result_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQUIRE, ST_CONVERT, ST_STORE} conv_state_t;

  // last count of the master clock divider: 00 /8, 01 /4, 10 /16, 11 /32
  function automatic logic [4:0] div_last(input logic [1:0] sel);
    case (sel)
      2'h0: div_last = 5'h07;
      2'h1: div_last = 5'h03;
      2'h2: div_last = 5'h0f;
      default: div_last = 5'h1f;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** verif/core_model.sv ***
// behavioural model of the analog SAR core and its input multiplexer
// assumes start pulses come from the control block, one conversion at a time
`default_nettype none
module core_model
#(
  parameter int CONV_CYCLES = 14
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic power_i,
  input wire logic [3:0] channel_i,
  input wire logic start_i,
  output logic done_o,
  output logic [11:0] code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic [3:0] ch_q;
  logic [11:0] last_q;
  // the code carries the channel, so a channel mix-up shows in the result
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt <= 0;
      done_o <= 1'b0;
      ch_q <= 4'h0;
      last_q <= 12'h000;
      code_o <= 12'hfff;
    end
    else
    begin
      done_o <= 1'b0;
      // outside the done pulse the code lines never show the last result
      code_o <= ~last_q;
      if (!power_i)
        cnt <= 0;
      else if (start_i)
      begin
        ch_q <= channel_i;
        cnt <= CONV_CYCLES;
      end
      else if (cnt == 1)
      begin
        done_o <= 1'b1;
        code_o <= 12'hac0 + {8'h00, ch_q};
        last_q <= 12'hac0 + {8'h00, ch_q};
        cnt <= 0;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_adc_control_config.sv ***
// self-checking bench of the converter control block, with the analog core model beside it
// assumes the bus answers in its own time and the core answers after a fixed count
`default_nettype none
module tb_adc_control_config
  import adc_control_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // factory calibration values, arbitrary
  localparam logic [15:0] CAL_O = 16'h0123;
  localparam logic [15:0] CAL_G = 16'h7a5c;
  logic clk_i, nrst_i, avs_read_i, avs_write_i, irq_ack_i, timer_overflow_i;
  logic external_convert_pin_n_i, dma_ready_i, core_done_i;
  logic [ADDR_BITS-1:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i, core_channel_o, ch;
  logic avs_waitrequest_o, irq_o, core_power_o, core_reference_select_bit_o, core_clk_o;
  logic core_track_o, core_start_o, dma_valid_o;
  logic [11:0] core_code_i, code;
  logic [15:0] cal_offset_o, cal_gain_o, dma_data_o;
  logic [23:0] dma_addr_o;
  int fails, checked, track_n, cycles, n;
  int dv[4] = '{8, 4, 16, 32};

  adc_control_config #(.CAL_OFFSET_FACTORY(CAL_O), .CAL_GAIN_FACTORY(CAL_G))
  i_adc_control_config (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .irq_ack_i(irq_ack_i),
    .timer_overflow_i(timer_overflow_i), .external_convert_pin_n_i(external_convert_pin_n_i),
    .core_power_o(core_power_o), .core_reference_select_bit_o(core_reference_select_bit_o), .core_clk_o(core_clk_o),
    .core_channel_o(core_channel_o), .core_track_o(core_track_o),
    .core_start_o(core_start_o), .core_done_i(core_done_i), .core_code_i(core_code_i),
    .cal_offset_o(cal_offset_o), .cal_gain_o(cal_gain_o), .dma_valid_o(dma_valid_o),
    .dma_ready_i(dma_ready_i), .dma_addr_o(dma_addr_o), .dma_data_o(dma_data_o));

  core_model #(.CONV_CYCLES(14)) i_core_model (.clk_i(clk_i), .nrst_i(nrst_i),
    .power_i(core_power_o), .channel_i(core_channel_o), .start_i(core_start_o),
    .done_o(core_done_i), .code_o(core_code_i));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(negedge clk_i)
    if (core_track_o === 1'b1)
      track_n++;

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // the request stands until the rising edge that samples waitrequest low; only the
  // bench timeout ends a wait
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do
      @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // one idle edge so the next request never lands in the same time step
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq_o !== 1'b1 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq_o});
    @(posedge clk_i);
  endtask

  task automatic div_period(input logic [1:0] sel, input int exp);
    int e;
    logic p;
    wr(OFS_CONTROL_ONE, {24'h0, 2'b10, sel, 4'h0});
    n = 0;
    e = 0;
    p = core_clk_o;
    while (e < 3 && n < 200)
    begin
      @(negedge clk_i);
      n++;
      if (core_clk_o === 1'b1 && p === 1'b0)
      begin
        e++;
        if (e == 2)
          n = 0;
      end
      p = core_clk_o;
    end
    chk("divider period", 32'(exp), 32'(n));
    @(posedge clk_i);
  endtask

  initial
  begin
    {avs_read_i, avs_write_i, irq_ack_i, timer_overflow_i, dma_ready_i} = 5'h00;
    external_convert_pin_n_i = 1'b1;
    avs_address_i = '0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    nrst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(OFS_CONTROL_ONE, 32'h00, "control one reset");
    chk("cal offset", {16'h0, CAL_O}, {16'h0, cal_offset_o});
    chk("cal gain", {16'h0, CAL_G}, {16'h0, cal_gain_o});
    n = 0;
    repeat (40) @(negedge clk_i) if (core_clk_o !== 1'b0) n++;
    chk("clock while off", 32'h0, 32'(n));
    @(posedge clk_i);
    rd(6'h3c, 32'h0, "unmapped read");
    wr(OFS_CONTROL_ONE, 32'h5a);
    rd(OFS_CONTROL_ONE, 32'h5a, "control one readback");
    chk("power and ref", 32'h1, {30'h0, core_power_o, core_reference_select_bit_o});
    wr(OFS_CONTROL_ONE, 32'ha5);
    rd(OFS_CONTROL_ONE, 32'ha5, "control one readback");
    chk("power and ref", 32'h2, {30'h0, core_power_o, core_reference_select_bit_o});
    for (int s = 0; s < 4; s++)
      div_period(2'(s), dv[s]);
    wr(OFS_IRQ_MASK, 32'h1);
    // one conversion per acquisition code, the last one on the temperature channel
    for (int i = 0; i < 4; i++)
    begin
      ch = (i == 3) ? TEMP_CHANNEL : 4'(2 * i + 1);
      code = 12'hac0 + {8'h0, ch};
      wr(OFS_CONTROL_ONE, 32'hb0 | 32'(i << 2));
      track_n = 0;
      wr(OFS_CONTROL_TWO, {24'h0, 4'h1, ch});
      wait_irq();
      chk("channel out", {28'h0, ch}, {28'h0, core_channel_o});
      chk("acquisition", 32'h1, 32'(track_n <= 32 * (i + 1) && track_n > 32 * i));
      rd(OFS_RESULT_LOW, {24'h0, code[7:0]}, "result low");
      rd(OFS_RESULT_HIGH, {24'h0, ch, code[11:8]}, "result high");
      wr(OFS_IRQ_STATUS, 32'h1);
      chk("irq after clear", 32'h0, {31'h0, irq_o});
    end
    wr(OFS_CONTROL_ONE, 32'hb2);
    wr(OFS_CONTROL_TWO, 32'h06);
    timer_overflow_i <= 1'b1;
    @(posedge clk_i);
    timer_overflow_i <= 1'b0;
    // a second overflow while busy is refused and flagged as missed
    repeat (3) @(posedge clk_i);
    timer_overflow_i <= 1'b1;
    @(posedge clk_i);
    timer_overflow_i <= 1'b0;
    wait_irq();
    rd(OFS_RESULT_HIGH, 32'h6a, "timer result high");
    wr(OFS_IRQ_MASK, 32'h0);
    chk("masked irq", 32'h0, {31'h0, irq_o});
    rd(OFS_IRQ_STATUS, 32'h3, "sticky status");
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h3);
    wr(OFS_CONTROL_ONE, 32'hb1);
    wr(OFS_CONTROL_TWO, 32'h03);
    external_convert_pin_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    external_convert_pin_n_i <= 1'b1;
    wait_irq();
    rd(OFS_RESULT_HIGH, 32'h3a, "pin result high");
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    @(posedge clk_i);
    rd(OFS_IRQ_STATUS, 32'h0, "status after vector");
    wr(OFS_CONTROL_ONE, 32'hb0);
    wr(OFS_CONTROL_TWO, 32'h25);
    wait_irq();
    wr(OFS_IRQ_STATUS, 32'h1);
    wait_irq();
    rd(OFS_CONTROL_TWO, 32'ha5, "continuous kept");
    wr(OFS_CONTROL_ONE, 32'h10);
    wr(OFS_CONTROL_TWO, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h3);
    wr(OFS_CONTROL_ONE, 32'hb4);
    wr(OFS_DMA_BASE, 32'h000100);
    wr(OFS_DMA_COUNT, 32'h2);
    wr(OFS_CONTROL_TWO, 32'h42);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      // step off the handshake edge first, where valid has not yet dropped
      do
      begin
        @(negedge clk_i);
        n++;
      end
      while (dma_valid_o !== 1'b1 && n < 3000);
      // the sink stalls a few cycles; the sample must stand meanwhile
      repeat (3) @(negedge clk_i);
      chk("dma valid", 32'h1, {31'h0, dma_valid_o});
      chk("dma addr", 32'h100 + 32'(2 * k), {8'h0, dma_addr_o});
      chk("dma data", 32'h2ac2, {16'h0, dma_data_o});
      @(posedge clk_i);
      dma_ready_i <= 1'b1;
      @(posedge clk_i);
      dma_ready_i <= 1'b0;
    end
    wait_irq();
    rd(OFS_CONTROL_TWO, 32'h82, "control two after dma");
    wrap_up();
  end
endmodule
`default_nettype wire
